// ### hw/svdc_pkg.sv
// Contract
// [R1] Enable bit D0 starts and stops monitoring.
// [R2] Result reads 1 below threshold, else 0.
// [R3] Flag sets on low supply while enabled.
// [R4] Flag stays set after supply recovers.
// [R5] Request asserted when flag and mask set.
// [R6] Mask resets to 0, blocking requests.
// [R7] Interrupt uses vector 9, offset 0x24.
// [R8] Four-bit threshold code, reset 0x0.
// [R9] Registers 8 bits, unused bits read 0.
// [R10] Software writes 0 to reserved bits.
// [R11] Enable bit resets to 0.
// [R12] Software waits 500 us before polling result.
// [R13] Handler clears flag before returning.
// [R14] Clear flag before setting the mask.
// [R15] Handler reads live result bit.
// [R16] Disable detection when not needed.
// [R17] Result is read-only, undefined after reset.
// [R18] Writing 1 clears flag; 0 no effect.
// [R19] Low-speed oscillator runs before enabling.
// [R20] Comparator output synchronised before use.
// [R21] Set beats clear in same cycle.
/*
 * Constants of the supply voltage detect control block: register
 * offsets, field positions, reset values and the interrupt vector.
 * Assumes byte addressing on a 32-bit Avalon-MM bus; the printed
 * offsets are indices, the byte address being four times the index.
 */
package svdc_pkg;

   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [15:0] IDX_DETECT_ENABLE    = 16'h5100;
   localparam logic [15:0] IDX_THRESHOLD_SELECT = 16'h5101;
   localparam logic [15:0] IDX_DETECT_RESULT    = 16'h5102;
   localparam logic [15:0] IDX_INTERRUPT_MASK   = 16'h5103;
   localparam logic [15:0] IDX_INTERRUPT_FLAG   = 16'h5104;
   localparam int          ADDR_W               = 18;
   localparam int          REG_W                = 8;
   localparam int          CODE_W               = 4;

   // ****************************************************************
   // Fields and resets.
   // ****************************************************************
   localparam int              BIT_D0           = 0;
   localparam logic            RST_ENABLE       = 1'b0;
   localparam logic            RST_MASK         = 1'b0;
   localparam logic            RST_FLAG         = 1'b0;
   localparam logic [3:0]      RST_CODE         = 4'h0;
   localparam logic [7:0]      IRQ_VECTOR       = 8'h09;
   localparam logic [7:0]      IRQ_VECTOR_OFS   = 8'h24;
   localparam logic [31:0]     READ_UNMAPPED    = 32'h0000_0000;

   // Bus slave states, Gray coded.
   typedef enum logic [1:0] {
      SVDC_IDLE = 2'b00,
      SVDC_DONE = 2'b01
   } svdc_bus_e;

   // Byte address of a register index.
   function automatic logic [17:0] svdc_byte_addr(input logic [15:0] idx);
      svdc_byte_addr = {idx, 2'b00};
   endfunction : svdc_byte_addr

endpackage : svdc_pkg

// ### hw/svdc_sync.sv
/*
 * Two-flop synchroniser for the asynchronous comparator output.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module svdc_sync
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;                   // [R20]
         sync_out <= meta_reg;                   // [R20]
      end
   end
endmodule : svdc_sync

// ### hw/svdc_avalon.sv
/*
 * Avalon-MM slave front end: one wait state, then a one-cycle answer.
 * Assumes the master holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
module svdc_avalon
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        read,
   input  wire logic        write,
   output logic             waitrequest,
   output logic             rd_stb,
   output logic             wr_stb
);
   svdc_pkg::svdc_bus_e state_reg;

   // Every access waits one cycle, giving registered read data time
   // to settle before the answer edge.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= svdc_pkg::SVDC_IDLE;
      else
      begin
         case (state_reg)
            svdc_pkg::SVDC_IDLE:
               if (read || write)
                  state_reg <= svdc_pkg::SVDC_DONE;
            default:
               state_reg <= svdc_pkg::SVDC_IDLE;
         endcase
      end
   end

   // Handshake outputs are combinational.
   always_comb
   begin
      waitrequest = (read || write) && (state_reg != svdc_pkg::SVDC_DONE);
      rd_stb      = read && (state_reg == svdc_pkg::SVDC_DONE);
      wr_stb      = write && (state_reg == svdc_pkg::SVDC_DONE);
   end
endmodule : svdc_avalon

// ### hw/svdc_top.sv
/*
 * Supply voltage detect control: registers over Avalon-MM, control of
 * the analog comparator, sticky low-voltage flag and interrupt request.
 * Assumes the comparator output is asynchronous and the interrupt
 * controller takes a level request.
 */
`timescale 1ns/1ps
module svdc_top
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic [17:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             COMPARATOR_ENABLE,
   output logic [3:0]       THRESHOLD_CODE,
   input  wire logic        COMPARATOR_BELOW,
   output logic             IRQ_REQUEST,
   output logic [7:0]       IRQ_VECTOR_NUMBER
);
   logic        wr_stb;
   logic        below_sync;
   logic        detect_enable_bit_reg;
   logic [3:0]  threshold_code_reg;
   logic        low_voltage_irq_enable_reg;
   logic        low_voltage_flag_reg;
   logic        low_voltage_flag_next;
   logic        below_threshold_result;
   logic        flag_set;
   logic        flag_clear;
   logic        hit_en;
   logic        hit_code;
   logic        hit_res;
   logic        hit_mask;
   logic        hit_flag;
   logic [31:0] read_next;

   // ****************************************************************
   // Bus front end and comparator synchroniser.
   // ****************************************************************
   svdc_avalon u_bus
   (
      .clk         (CLK_SYS),
      .reset_n     (RESET_N),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .waitrequest (AVS_WAITREQUEST),
      .rd_stb      (),
      .wr_stb      (wr_stb)
   );

   svdc_sync u_sync
   (
      .clk      (CLK_SYS),
      .reset_n  (RESET_N),
      .async_in (COMPARATOR_BELOW),
      .sync_out (below_sync)
   );

   // ****************************************************************
   // Address decode.
   // ****************************************************************
   always_comb
   begin
      hit_en   = 1'b0;
      hit_code = 1'b0;
      hit_res  = 1'b0;
      hit_mask = 1'b0;
      hit_flag = 1'b0;
      if (AVS_ADDRESS ==
          svdc_pkg::svdc_byte_addr(svdc_pkg::IDX_DETECT_ENABLE))
         hit_en = 1'b1;
      else if (AVS_ADDRESS ==
               svdc_pkg::svdc_byte_addr(svdc_pkg::IDX_THRESHOLD_SELECT))
         hit_code = 1'b1;
      else if (AVS_ADDRESS ==
               svdc_pkg::svdc_byte_addr(svdc_pkg::IDX_DETECT_RESULT))
         hit_res = 1'b1;
      else if (AVS_ADDRESS ==
               svdc_pkg::svdc_byte_addr(svdc_pkg::IDX_INTERRUPT_MASK))
         hit_mask = 1'b1;
      else if (AVS_ADDRESS ==
               svdc_pkg::svdc_byte_addr(svdc_pkg::IDX_INTERRUPT_FLAG))
         hit_flag = 1'b1;
   end

   // ****************************************************************
   // Control registers.
   // ****************************************************************
   // Only the low byte lane carries register data; reserved bits
   // written by software are simply dropped.
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         detect_enable_bit_reg <= svdc_pkg::RST_ENABLE;    // [R11]
      else if (wr_stb && hit_en && AVS_BYTEENABLE[0])
         detect_enable_bit_reg <= AVS_WRITEDATA[svdc_pkg::BIT_D0]; // [R1]
   end

   // Code 0x0 is reserved but stored as written; the comparator is
   // left to treat it as it will.
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         threshold_code_reg <= svdc_pkg::RST_CODE;         // [R8]
      else if (wr_stb && hit_code && AVS_BYTEENABLE[0])
         threshold_code_reg <= AVS_WRITEDATA[svdc_pkg::CODE_W-1:0]; // [R8]
   end

   // Mask resets closed so no request leaves before software asks.
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         low_voltage_irq_enable_reg <= svdc_pkg::RST_MASK; // [R6]
      else if (wr_stb && hit_mask && AVS_BYTEENABLE[0])
         low_voltage_irq_enable_reg <= AVS_WRITEDATA[svdc_pkg::BIT_D0];
   end

   // ****************************************************************
   // Detection result and sticky flag.
   // ****************************************************************
   // The result is meaningful only while detection runs; gating with
   // the enable blocks the comparator level while detection is off, but
   // the stopped comparator's level still held in the synchroniser sets the flag in the two cycles after enabling.
   always_comb
   begin
      below_threshold_result = below_sync;                 // [R2] [R17]
      flag_set   = detect_enable_bit_reg && below_sync;    // [R3] [R20]
      flag_clear = wr_stb && hit_flag && AVS_BYTEENABLE[0]
                   && AVS_WRITEDATA[svdc_pkg::BIT_D0];     // [R18]
      low_voltage_flag_next = low_voltage_flag_reg;        // [R4]
      if (flag_set)
         low_voltage_flag_next = 1'b1;                     // [R21]
      else if (flag_clear)
         low_voltage_flag_next = 1'b0;                     // [R18]
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         low_voltage_flag_reg <= svdc_pkg::RST_FLAG;
      else
         low_voltage_flag_reg <= low_voltage_flag_next;
   end

   // ****************************************************************
   // Read data path.
   // ****************************************************************
   always_comb
   begin
      read_next = svdc_pkg::READ_UNMAPPED;                 // [R9]
      if (hit_en)
         read_next[svdc_pkg::BIT_D0] = detect_enable_bit_reg;
      else if (hit_code)
         read_next[svdc_pkg::CODE_W-1:0] = threshold_code_reg;
      else if (hit_res)
         read_next[svdc_pkg::BIT_D0] = below_threshold_result; // [R2]
      else if (hit_mask)
         read_next[svdc_pkg::BIT_D0] = low_voltage_irq_enable_reg;
      else if (hit_flag)
         read_next[svdc_pkg::BIT_D0] = low_voltage_flag_reg;
   end

   // Read data are loaded during the wait cycle and stand at the answer.
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         AVS_READDATA <= svdc_pkg::READ_UNMAPPED;
      else if (AVS_READ && AVS_WAITREQUEST)
         AVS_READDATA <= read_next;
   end

   // ****************************************************************
   // Outputs to comparator and interrupt controller.
   // ****************************************************************
   always_comb
   begin
      COMPARATOR_ENABLE = detect_enable_bit_reg;           // [R1]
      THRESHOLD_CODE    = threshold_code_reg;              // [R8]
      IRQ_REQUEST       = low_voltage_flag_reg
                          && low_voltage_irq_enable_reg;   // [R5] [R6]
      IRQ_VECTOR_NUMBER = svdc_pkg::IRQ_VECTOR;            // [R7]
   end
endmodule : svdc_top

// ### tb/svdc_top_asserts.sv
/* Port checker for svdc_top.
   Assumes a bind onto svdc_top with every port joined by name. */
`timescale 1ns/1ps
module svdc_top_asserts
(
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   input wire logic [17:0] AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        COMPARATOR_ENABLE,
   input wire logic [3:0]  THRESHOLD_CODE,
   input wire logic        COMPARATOR_BELOW,
   input wire logic        IRQ_REQUEST,
   input wire logic [7:0]  IRQ_VECTOR_NUMBER
);
   // ******************
   // Helpers and checks
   // ******************
   logic wr_acc;
   logic mask_reg;
   // A write is taken when waitrequest is low and lane zero is on.
   assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   // Own copy of the mask, so the checker does not trust the design's.
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         mask_reg <= 1'b0;
      else if (wr_acc && AVS_ADDRESS == 18'h1440c)
         mask_reg <= AVS_WRITEDATA[0];
   end
   default clocking dc @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   // Armed and low for four cycles, long enough to pass the synchroniser.
   sequence s_low_held;
      (COMPARATOR_ENABLE && mask_reg && COMPARATOR_BELOW) [*4];
   endsequence
   a_vector_fixed: assert property (IRQ_VECTOR_NUMBER == 8'h09)
      else $error("vector number wrong");
   a_enable_write: assert property (wr_acc && AVS_ADDRESS == 18'h14400
      |=> COMPARATOR_ENABLE == $past(AVS_WRITEDATA[0])) else $error("enable");
   a_enable_hold: assert property (!$stable(COMPARATOR_ENABLE)
      |-> $past(wr_acc)) else $error("enable moved without write");
   a_code_write: assert property (wr_acc && AVS_ADDRESS == 18'h14404
      |=> THRESHOLD_CODE == $past(AVS_WRITEDATA[3:0])) else $error("code");
   a_unused_zero: assert property (AVS_READ && !AVS_WAITREQUEST
      |-> AVS_READDATA[31:8] == 24'h0) else $error("upper bits set");
   a_mask_blocks: assert property (!mask_reg |-> !IRQ_REQUEST)
      else $error("request while masked");
   a_low_sets_flag: assert property (s_low_held |-> IRQ_REQUEST)
      else $error("low supply raised no request");
   a_irq_cause: assert property ($rose(IRQ_REQUEST) |-> $past(wr_acc)
      || $past(COMPARATOR_BELOW, 2) || $past(COMPARATOR_BELOW, 3))
      else $error("request without cause");
   a_flag_sticky: assert property ($fell(IRQ_REQUEST) |-> $past(wr_acc))
      else $error("request dropped without write");
   a_below_synced: assert property ($rose(COMPARATOR_BELOW) && !wr_acc
      |=> !$rose(IRQ_REQUEST)) else $error("comparator not synchronised");
endmodule : svdc_top_asserts

// ### tb/svdc_comparator_model.sv
/* Behavioural model of the analog supply comparator.
   Assumes the bench sets the supply level in millivolts. */
`timescale 1ns/1ps
module svdc_comparator_model
(
   input wire logic       enable,
   input wire logic [3:0] code,
   input int              supply_mv,
   output logic           below
);
   int threshold_mv;
   // Code one is 1.8 V and each step adds 0.1 V.
   assign threshold_mv = 1700 + 100 * int'(code);
   // The low-speed oscillator is taken as running from the start.
   // A stopped comparator drives no defined level; the model shows a
   // drop then, so the design's gating by the enable bit is tested.
   // The reserved code reports no drop.
   assign below = enable ? (code != 4'h0 && supply_mv < threshold_mv)
                         : 1'b1;
endmodule : svdc_comparator_model

// ### tb/svdc_top_tb.sv
/* Self-checking bench for svdc_top with a comparator model.
   Assumes the package, the design and the checker are compiled first. */
`timescale 1ns/1ps
module svdc_top_tb;
   logic        CLK_SYS, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic        COMPARATOR_ENABLE, COMPARATOR_BELOW, IRQ_REQUEST;
   logic [17:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
   logic [3:0]  AVS_BYTEENABLE, THRESHOLD_CODE;
   logic [7:0]  IRQ_VECTOR_NUMBER;
   int          supply_mv, failures, comparisons;
   // Settle time after enabling: 500 us at 40 ns a cycle.
   localparam int SETTLE_CYCLES = 12500;

   svdc_top uut
   (
      .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .COMPARATOR_ENABLE(COMPARATOR_ENABLE), .THRESHOLD_CODE(THRESHOLD_CODE),
      .COMPARATOR_BELOW(COMPARATOR_BELOW), .IRQ_REQUEST(IRQ_REQUEST),
      .IRQ_VECTOR_NUMBER(IRQ_VECTOR_NUMBER)
   );
   svdc_comparator_model u_cmp
   (
      .enable(COMPARATOR_ENABLE), .code(THRESHOLD_CODE),
      .supply_mv(supply_mv), .below(COMPARATOR_BELOW)
   );
   // Free-running 25 MHz clock.
   initial
   begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One bus cycle, held until waitrequest is seen low at an edge.
   task automatic bus(input logic w, input logic [15:0] idx,
                      input logic [7:0] d);
      AVS_ADDRESS   <= {idx, 2'b00};
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE     <= w;
      AVS_READ      <= !w;
      @(posedge CLK_SYS iff AVS_WAITREQUEST == 1'b0);
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
      @(posedge CLK_SYS);
   endtask : bus
   task automatic rdchk(input string what, input logic [15:0] idx,
                        input logic [31:0] exp);
      // Let a comparator change pass the two-flop synchroniser first.
      repeat (2) @(posedge CLK_SYS);
      bus(1'b0, idx, 8'h00);
      check(what, rd, exp);
   endtask : rdchk
   task automatic t_reset;
      rdchk("enable", 16'h5100, 32'h0);
      rdchk("code", 16'h5101, 32'h0);
      rdchk("mask", 16'h5103, 32'h0);
      rdchk("flag", 16'h5104, 32'h0);
      rdchk("unmapped", 16'h5105, 32'h0);
      check("vector", {24'h0, IRQ_VECTOR_NUMBER}, 32'h9);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_regs;
      bus(1'b1, 16'h5100, 8'h01);
      // Polling software lets the comparator settle after enabling.
      repeat (SETTLE_CYCLES) @(posedge CLK_SYS);
      rdchk("enable", 16'h5100, 32'h1);
      for (int c = 1; c < 16; c++)
      begin
         bus(1'b1, 16'h5101, 8'(c));
         rdchk("code", 16'h5101, 32'(c));
         @(negedge CLK_SYS);
         check("code_pin", {28'h0, THRESHOLD_CODE}, 32'(c));
         @(posedge CLK_SYS);
      end
      $display("t_regs done");
   endtask : t_regs
   task automatic t_detect;
      bus(1'b1, 16'h5101, 8'h08);
      rdchk("result_eq", 16'h5102, 32'h0);
      bus(1'b1, 16'h5104, 8'h01);
      rdchk("flag_clr", 16'h5104, 32'h0);
      bus(1'b1, 16'h5101, 8'h09);
      rdchk("result_low", 16'h5102, 32'h1);
      rdchk("flag_set", 16'h5104, 32'h1);
      supply_mv <= 3300;
      rdchk("result_ok", 16'h5102, 32'h0);
      bus(1'b1, 16'h5102, 8'h01);
      rdchk("result_ro", 16'h5102, 32'h0);
      rdchk("flag_kept", 16'h5104, 32'h1);
      bus(1'b1, 16'h5104, 8'h00);
      rdchk("flag_w0", 16'h5104, 32'h1);
      bus(1'b1, 16'h5104, 8'h01);
      rdchk("flag_w1", 16'h5104, 32'h0);
      bus(1'b1, 16'h5103, 8'h01);
      supply_mv <= 2000;
      repeat (4) @(negedge CLK_SYS);
      check("irq_on", {31'h0, IRQ_REQUEST}, 32'h1);
      @(posedge CLK_SYS);
      rdchk("result_live", 16'h5102, 32'h1);
      bus(1'b1, 16'h5104, 8'h01);
      rdchk("flag_setwin", 16'h5104, 32'h1);
      supply_mv <= 3300;
      repeat (4) @(posedge CLK_SYS);
      bus(1'b1, 16'h5104, 8'h01);
      @(negedge CLK_SYS);
      check("irq_off", {31'h0, IRQ_REQUEST}, 32'h0);
      @(posedge CLK_SYS);
      bus(1'b1, 16'h5100, 8'h00);
      supply_mv <= 2000;
      repeat (4) @(posedge CLK_SYS);
      rdchk("flag_off", 16'h5104, 32'h0);
      AVS_BYTEENABLE <= 4'he;
      bus(1'b1, 16'h5100, 8'h01);
      AVS_BYTEENABLE <= 4'hf;
      rdchk("lane_off", 16'h5100, 32'h0);
      $display("t_detect done");
   endtask : t_detect
   task automatic print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // Main sequence; supply starts at 2.5 V for the edge case later on.
   initial
   begin
      RESET_N        = 1'b0;
      AVS_ADDRESS    = 18'h0;
      AVS_READ       = 1'b0;
      AVS_WRITE      = 1'b0;
      AVS_WRITEDATA  = 32'h0;
      AVS_BYTEENABLE = 4'hf;
      supply_mv      = 2500;
      failures       = 0;
      comparisons    = 0;
      repeat (12) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      t_reset;
      t_regs;
      t_detect;
      print_verdict;
   end
   // Tests need about 13000 cycles, mostly the settle wait; this cuts
   // a hang short.
   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      failures++;
      print_verdict;
   end
endmodule : svdc_top_tb

bind svdc_top svdc_top_asserts u_chk
(
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .COMPARATOR_ENABLE(COMPARATOR_ENABLE), .THRESHOLD_CODE(THRESHOLD_CODE),
   .COMPARATOR_BELOW(COMPARATOR_BELOW), .IRQ_REQUEST(IRQ_REQUEST),
   .IRQ_VECTOR_NUMBER(IRQ_VECTOR_NUMBER)
);
